/* ipvr_regs.vh */
// Register offsets, field positions, reset values and vector constants of the resolver
`ifndef IPVR_REGS_VH
`define IPVR_REGS_VH

// ************************************************************
// Register byte offsets
// ************************************************************
`define IPVR_OFS_SYS_CTRL 12'h000
`define IPVR_OFS_LEVEL 12'h004
`define IPVR_OFS_VECTOR 12'h008
`define IPVR_OFS_INT_STAT 12'h00C
`define IPVR_OFS_INT_MASK 12'h010

// ************************************************************
// Field positions
// ************************************************************
`define IPVR_SYS_MODE_BIT 0
`define IPVR_SYS_ADV_BIT 1
`define IPVR_VEC_VALID_BIT 8
`define IPVR_EV_PRESENT 0
`define IPVR_EV_ACK 1
`define IPVR_EV_NMI 2
`define IPVR_EV_W 3

// ************************************************************
// Reset values
// ************************************************************
`define IPVR_SYS_CTRL_RST 2'h0
`define IPVR_LEVEL_RST 16'h0000
`define IPVR_INT_MASK_RST 3'h0

// ************************************************************
// Vector numbers
// ************************************************************
`define IPVR_NVEC 56
`define IPVR_VEC_NMI 7
`define IPVR_VEC_IRQ0 16
`define IPVR_VEC_SWDT 24
`define IPVR_VEC_WDT0 25
`define IPVR_VEC_WDT1 26
`define IPVR_VEC_ABRK 27
`define IPVR_VEC_CONV 28
`define IPVR_VEC_FRT0 48

`endif

/* ipvr_prio_enc.v */
// Finds the lowest-numbered set request in a vector-indexed request word
`timescale 1ns/1ps
module ipvr_prio_enc #(
  parameter NVEC = 56,
  parameter VW = 6
) (
  // Requests indexed by vector number
  input wire [NVEC-1:0] req,
  // Winner
  output reg found,
  output reg [VW-1:0] idx
);
  integer i;

  // ************************************************************
  // Lowest vector number wins
  // ************************************************************
  always @* begin
    found = 1'b0;
    idx = {VW{1'b0}};
    for (i = NVEC - 1; i >= 0; i = i - 1) begin
      if (req[i]) begin
        found = 1'b1;
        idx = i[VW-1:0];
      end
    end
  end
endmodule // ipvr_prio_enc

/* ipvr_vec_addr.v */
// Forms the vector table address from a vector number
`timescale 1ns/1ps
module ipvr_vec_addr #(
  parameter VW = 6,
  parameter AW = 24
) (
  // Vector number and address mode
  input wire [VW-1:0] vec,
  input wire advanced,
  // Table address
  output wire [AW-1:0] addr
);
  // ************************************************************
  // Two bytes per entry normal, four advanced
  // ************************************************************
  assign addr = advanced ? {{(AW-VW-2){1'b0}}, vec, 2'b00} : {{(AW-VW-1){1'b0}}, vec, 1'b0};
endmodule // ipvr_vec_addr

/* ipvr_resolver.v */
// Interrupt priority and vector resolver with APB register access
//
// Register access over APB and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "ipvr_regs.vh"

// Notes on behaviour
// - Equal level: smallest pending vector number wins.
// - Same-level modules ordered only by fixed vector ranking, no extra state.
// - Order of sources inside a module is fixed by vector number.
// - One level bit per module group; address break has none.
// - Level 1 requests are served before any level 0 request except address break, which ranks in the level 1 group.
// - Transfer-done request at vector 24 under the transfer level bit.
// - Converter done at vector 28 under its own level bit.
// - Timer capture, compare, overflow on vectors 48 to 54, one level bit.
// - Reserved vectors 29 to 47 and 55 never requested.
// - Nonmaskable pin interrupt is top priority and never masked.
// - Mode 1 masks with both mask bits and level; mode 0 with one bit.
module ipvr_resolver #(
  parameter NVEC = `IPVR_NVEC,
  parameter VW = 6,
  parameter AW = 24
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Processor mask bits
  input wire cpu_i_mask,
  input wire user_mask_bit,
  // External pin requests
  input wire nmi_req,
  input wire [7:0] irq_req,
  // Peripheral requests
  input wire sw_transfer_done_req,
  input wire wdt0_req,
  input wire wdt1_req,
  input wire addr_break_req,
  input wire conv_done_req,
  input wire capture_a_req,
  input wire capture_b_req,
  input wire capture_c_req,
  input wire capture_d_req,
  input wire compare_a_req,
  input wire compare_b_req,
  input wire timer_overflow_req,
  // Exception sequencer
  input wire core_ack,
  output reg vec_valid,
  output reg [VW-1:0] vec_num,
  output reg [AW-1:0] vec_addr,
  // Interrupt line
  output reg irq_out
);

  // ************************************************************
  // Registers
  // ************************************************************
  reg [1:0] system_control_reg;
  reg [15:0] control_level_reg;
  reg [`IPVR_EV_W-1:0] int_stat;
  reg [`IPVR_EV_W-1:0] int_mask;
  reg nmi_prev;

  wire ctrl_mode = system_control_reg[`IPVR_SYS_MODE_BIT];
  wire adv_mode = system_control_reg[`IPVR_SYS_ADV_BIT];

  // Level bits of each module group
  wire [7:0] lvl_a = control_level_reg[15:8];
  wire [7:0] lvl_b = control_level_reg[7:0];
  wire level_bit_transfer = lvl_a[2];
  wire level_bit_converter = lvl_b[7];
  wire level_bit_freetimer = lvl_b[6];

  // ************************************************************
  // Request and level words by vector number
  // ************************************************************
  reg [NVEC-1:0] req_vec;
  reg [NVEC-1:0] lvl_vec;
  reg [NVEC-1:0] nomask_vec;

  always @* begin
    req_vec = {NVEC{1'b0}};
    lvl_vec = {NVEC{1'b0}};
    nomask_vec = {NVEC{1'b0}};
    req_vec[`IPVR_VEC_NMI] = nmi_req;
    nomask_vec[`IPVR_VEC_NMI] = 1'b1;
    lvl_vec[`IPVR_VEC_NMI] = 1'b1;
    req_vec[`IPVR_VEC_IRQ0 +: 8] = irq_req;
    lvl_vec[`IPVR_VEC_IRQ0] = lvl_a[7];
    lvl_vec[`IPVR_VEC_IRQ0 + 1] = lvl_a[6];
    lvl_vec[`IPVR_VEC_IRQ0 + 2] = lvl_a[5];
    lvl_vec[`IPVR_VEC_IRQ0 + 3] = lvl_a[5];
    lvl_vec[`IPVR_VEC_IRQ0 + 4] = lvl_a[4];
    lvl_vec[`IPVR_VEC_IRQ0 + 5] = lvl_a[4];
    lvl_vec[`IPVR_VEC_IRQ0 + 6] = lvl_a[3];
    lvl_vec[`IPVR_VEC_IRQ0 + 7] = lvl_a[3];
    req_vec[`IPVR_VEC_SWDT] = sw_transfer_done_req;
    lvl_vec[`IPVR_VEC_SWDT] = level_bit_transfer;
    req_vec[`IPVR_VEC_WDT0] = wdt0_req;
    lvl_vec[`IPVR_VEC_WDT0] = lvl_a[1];
    req_vec[`IPVR_VEC_WDT1] = wdt1_req;
    lvl_vec[`IPVR_VEC_WDT1] = lvl_a[0];
    req_vec[`IPVR_VEC_ABRK] = addr_break_req;
    lvl_vec[`IPVR_VEC_ABRK] = 1'b0;
    nomask_vec[`IPVR_VEC_ABRK] = 1'b1;
    req_vec[`IPVR_VEC_CONV] = conv_done_req;
    lvl_vec[`IPVR_VEC_CONV] = level_bit_converter;
    req_vec[`IPVR_VEC_FRT0 +: 7] = {timer_overflow_req, compare_b_req, compare_a_req,
                                    capture_d_req, capture_c_req, capture_b_req, capture_a_req};
    lvl_vec[`IPVR_VEC_FRT0 +: 7] = {7{level_bit_freetimer}};
  end

  // ************************************************************
  // Mask control
  // ************************************************************
  reg accept_lvl0;
  reg accept_lvl1;

  always @* begin
    accept_lvl1 = 1'b0;
    accept_lvl0 = 1'b0;
    case ({ctrl_mode, cpu_i_mask, user_mask_bit})
      3'h0, 3'h1: begin
        accept_lvl1 = 1'b1;
        accept_lvl0 = 1'b1;
      end
      3'h2, 3'h3: begin
        accept_lvl1 = 1'b0;
        accept_lvl0 = 1'b0;
      end
      3'h4, 3'h5: begin
        accept_lvl1 = 1'b1;
        accept_lvl0 = 1'b1;
      end
      3'h6: begin
        accept_lvl1 = 1'b1;
        accept_lvl0 = 1'b0;
      end
      default: begin
        accept_lvl1 = 1'b0;
        accept_lvl0 = 1'b0;
      end
    endcase
  end

  // Unmasked requests split by level; nonmaskable ones join the top group
  wire [NVEC-1:0] top_req = req_vec & ((lvl_vec & {NVEC{accept_lvl1}}) | nomask_vec);
  wire [NVEC-1:0] low_req = req_vec & ~lvl_vec & ~nomask_vec & {NVEC{accept_lvl0}};

  wire top_found;
  wire low_found;
  wire [VW-1:0] top_idx;
  wire [VW-1:0] low_idx;

  ipvr_prio_enc #(.NVEC(NVEC), .VW(VW)) u_top_enc (
    .req(top_req),
    .found(top_found),
    .idx(top_idx)
  );

  ipvr_prio_enc #(.NVEC(NVEC), .VW(VW)) u_low_enc (
    .req(low_req),
    .found(low_found),
    .idx(low_idx)
  );

  wire any_pending = top_found | low_found;
  wire [VW-1:0] win_idx = top_found ? top_idx : low_idx;

  wire [AW-1:0] win_addr;

  ipvr_vec_addr #(.VW(VW), .AW(AW)) u_addr (
    .vec(win_idx),
    .advanced(adv_mode),
    .addr(win_addr)
  );

  // ************************************************************
  // Vector presentation
  // ************************************************************
  wire present_ev = ~vec_valid & any_pending;
  wire ack_ev = vec_valid & core_ack;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vec_valid <= 1'b0;
      vec_num <= {VW{1'b0}};
      vec_addr <= {AW{1'b0}};
    end else if (vec_valid) begin
      if (core_ack || !any_pending) begin
        vec_valid <= 1'b0;
      end
    end else if (any_pending) begin
      vec_valid <= 1'b1;
      vec_num <= win_idx;
      vec_addr <= win_addr;
    end
  end

  // ************************************************************
  // APB access
  // ************************************************************
  // Address match of one register
  function hit_reg;
    input [11:0] addr;
    input [11:0] ofs;
    begin
      hit_reg = addr == ofs;
    end
  endfunction

  wire acc_phase = psel & penable & ~pready;
  wire wr_done = psel & penable & pready & pwrite;
  wire hit_sys = hit_reg(paddr, `IPVR_OFS_SYS_CTRL);
  wire hit_lvl = hit_reg(paddr, `IPVR_OFS_LEVEL);
  wire hit_vec = hit_reg(paddr, `IPVR_OFS_VECTOR);
  wire hit_sta = hit_reg(paddr, `IPVR_OFS_INT_STAT);
  wire hit_msk = hit_reg(paddr, `IPVR_OFS_INT_MASK);
  wire hit_any = hit_sys | hit_lvl | hit_vec | hit_sta | hit_msk;

  reg [31:0] next_prdata;

  always @* begin
    next_prdata = 32'h00000000;
    case (1'b1)
      hit_sys: next_prdata[1:0] = system_control_reg;
      hit_lvl: next_prdata[15:0] = control_level_reg;
      hit_vec: begin
        next_prdata[VW-1:0] = vec_num;
        next_prdata[`IPVR_VEC_VALID_BIT] = vec_valid;
      end
      hit_sta: next_prdata[`IPVR_EV_W-1:0] = int_stat;
      hit_msk: next_prdata[`IPVR_EV_W-1:0] = int_mask;
      default: next_prdata = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready <= acc_phase;
      pslverr <= acc_phase & ~hit_any;
      if (acc_phase && !pwrite) begin
        prdata <= next_prdata;
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      system_control_reg <= `IPVR_SYS_CTRL_RST;
      control_level_reg <= `IPVR_LEVEL_RST;
      int_mask <= `IPVR_INT_MASK_RST;
    end else if (wr_done) begin
      if (hit_sys) begin
        system_control_reg <= pwdata[1:0];
      end
      if (hit_lvl) begin
        control_level_reg <= pwdata[15:0];
      end
      if (hit_msk) begin
        int_mask <= pwdata[`IPVR_EV_W-1:0];
      end
    end
  end

  // ************************************************************
  // Event status and interrupt line
  // ************************************************************
  wire nmi_rise = nmi_req & ~nmi_prev;
  wire sta_wr = wr_done & hit_sta;
  reg [`IPVR_EV_W-1:0] ev_set;

  always @* begin
    ev_set = {`IPVR_EV_W{1'b0}};
    ev_set[`IPVR_EV_PRESENT] = present_ev;
    ev_set[`IPVR_EV_ACK] = ack_ev;
    ev_set[`IPVR_EV_NMI] = nmi_rise;
  end

  // Writing one clears a bit; a same-cycle event keeps it set
  wire [`IPVR_EV_W-1:0] ev_clr = sta_wr ? pwdata[`IPVR_EV_W-1:0] : {`IPVR_EV_W{1'b0}};
  wire [`IPVR_EV_W-1:0] next_int_stat = (int_stat & ~ev_clr) | ev_set;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat <= {`IPVR_EV_W{1'b0}};
      nmi_prev <= 1'b0;
      irq_out <= 1'b0;
    end else begin
      int_stat <= next_int_stat;
      nmi_prev <= nmi_req;
      irq_out <= |(next_int_stat & int_mask);
    end
  end
endmodule // ipvr_resolver

/* ipvr_core_model.sv */
// Exception sequencer model that acknowledges a presented vector
`timescale 1ns/1ps
module ipvr_core_model (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Vector handshake
  input wire vec_valid,
  input wire [3:0] dly,
  output reg core_ack
);
  reg [3:0] cnt;
  // ****
  // Acknowledge dly+1 cycles after a vector is presented
  // ****
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      core_ack <= 1'h0;
    end else begin
      core_ack <= vec_valid && !core_ack && cnt >= dly;
      cnt <= (vec_valid && !core_ack) ? cnt + 4'h1 : 4'h0;
    end
  end
endmodule // ipvr_core_model

/* ipvr_resolver_checker.sv */
// Port assertions of the interrupt vector resolver
`timescale 1ns/1ps
module ipvr_resolver_checker (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Watched ports
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  input wire nmi_req,
  input wire core_ack,
  input wire vec_valid,
  input wire [5:0] vec_num,
  input wire [23:0] vec_addr
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_addr_form:
    assert property (vec_valid |-> (vec_addr == {vec_num, 1'h0} || vec_addr == {vec_num, 2'h0}))
    else $error("vector address not formed from number");
  a_no_reserved:
    assert property (vec_valid |-> !((vec_num >= 29 && vec_num <= 47) || vec_num == 55))
    else $error("reserved vector presented");
  a_nmi_first:
    assert property (nmi_req && !vec_valid |=> vec_valid && vec_num == 7)
    else $error("pin nonmaskable request not taken first");
  a_vec_hold:
    assert property (vec_valid && !core_ack |=> !vec_valid || ($stable(vec_num) && $stable(vec_addr)))
    else $error("vector changed before acknowledge");
  a_ack_gap:
    assert property (vec_valid && core_ack |=> !vec_valid)
    else $error("vector still shown after acknowledge");
  a_ready_late:
    assert property (psel && penable && !pready |=> pready)
    else $error("ready not given in second access cycle");
  a_ready_pulse:
    assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_ready:
    assert property (pslverr |-> pready)
    else $error("error without ready");
endmodule // ipvr_resolver_checker
bind ipvr_resolver ipvr_resolver_checker u_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .nmi_req, .core_ack, .vec_valid, .vec_num, .vec_addr);

/* ipvr_resolver_tb_top.sv */
// Self-checking testbench of the interrupt vector resolver
`timescale 1ns/1ps
`include "ipvr_regs.vh"
module ipvr_resolver_tb_top;
  // ****
  // Signals
  // ****
  typedef struct packed {logic [20:0] r; logic [15:0] lv; logic [3:0] c; logic [5:0] n;} ipvr_row_t;
  logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, ci = 1'h0, ui = 1'h0, e;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, q;
  logic [20:0] rq = 21'h0;
  logic [3:0] dly = 4'h2;
  logic [11:0] ra [4] = '{`IPVR_OFS_SYS_CTRL, `IPVR_OFS_LEVEL, `IPVR_OFS_VECTOR, `IPVR_OFS_INT_MASK};
  wire [31:0] prdata;
  wire pready, pslverr, core_ack, vec_valid, irq_out;
  wire [5:0] vec_num;
  wire [23:0] vec_addr;
  int errors = 0, tests_run = 0, j;
  ipvr_row_t rows [17];
  ipvr_resolver dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .cpu_i_mask(ci), .user_mask_bit(ui), .nmi_req(rq[20]), .irq_req(rq[19:12]),
    .sw_transfer_done_req(rq[11]), .wdt0_req(rq[10]), .wdt1_req(rq[9]), .addr_break_req(rq[8]),
    .conv_done_req(rq[7]), .capture_a_req(rq[6]), .capture_b_req(rq[5]), .capture_c_req(rq[4]),
    .capture_d_req(rq[3]), .compare_a_req(rq[2]), .compare_b_req(rq[1]), .timer_overflow_req(rq[0]),
    .core_ack, .vec_valid, .vec_num, .vec_addr, .irq_out);
  ipvr_core_model core (.pclk, .presetn, .vec_valid, .dly, .core_ack);
  // ****
  // Tasks
  // ****
  function automatic ipvr_row_t mk(logic [20:0] r, logic [15:0] lv, logic [3:0] c, logic [5:0] n);
    mk = {r, lv, c, n};
  endfunction
  task end_of_test;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(string n, logic [31:0] s, logic [31:0] x);
    tests_run++;
    if (s !== x) begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, x, s);
    end
  endtask
  task apb(logic w, logic [11:0] a, logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'h1) break;
    end
    if (k == 20) chk("pready", pready, 32'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task wv(logic v);
    int k;
    for (k = 0; k < 20; k++) begin
      @(negedge pclk);
      if (vec_valid === v) break;
    end
    chk("vec_valid", vec_valid, v);
  endtask
  // ****
  // Sequence
  // ****
  initial forever #25 pclk = ~pclk;
  initial begin
    #200000;
    errors++;
    end_of_test();
  end
  initial begin
    rows[0] = mk(21'h001000, 16'h0000, 4'h0, 6'h10);
    rows[1] = mk(21'h000800, 16'h0000, 4'h2, 6'h18);
    rows[2] = mk(21'h000080, 16'h0000, 4'h0, 6'h1C);
    rows[3] = mk(21'h000001, 16'h0000, 4'h2, 6'h36);
    rows[4] = mk(21'h00007F, 16'h0000, 4'h0, 6'h30);
    rows[5] = mk(21'h00000A, 16'h0000, 4'h0, 6'h33);
    rows[6] = mk(21'h003000, 16'h0000, 4'h0, 6'h10);
    rows[7] = mk(21'h002200, 16'h4100, 4'h0, 6'h11);
    rows[8] = mk(21'h001080, 16'h0080, 4'h0, 6'h1C);
    rows[9] = mk(21'h001040, 16'h0040, 4'h0, 6'h30);
    rows[10] = mk(21'h101000, 16'h8000, 4'h8, 6'h07);
    rows[11] = mk(21'h001080, 16'h0080, 4'h9, 6'h1C);
    rows[12] = mk(21'h000100, 16'h0000, 4'h8, 6'h1B);
    rows[13] = mk(21'h001100, 16'h8000, 4'h8, 6'h1B);
    rows[14] = mk(21'h001100, 16'h8000, 4'h9, 6'h10);
    rows[15] = mk(21'h001100, 16'h8000, 4'hD, 6'h1B);
    rows[16] = mk(21'h000600, 16'h0100, 4'h0, 6'h1A);
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    for (j = 0; j < 4; j++) begin
      apb(1'h0, ra[j], 32'h0);
      chk("reset value", q, 32'h0);
    end
    apb(1'h0, 12'h020, 32'h0);
    chk("pslverr", e, 32'h1);
    for (j = 0; j < 17; j++) begin
      apb(1'h1, `IPVR_OFS_LEVEL, rows[j].lv);
      apb(1'h1, `IPVR_OFS_SYS_CTRL, rows[j].c[1:0]);
      ci <= rows[j].c[3];
      ui <= rows[j].c[2];
      rq <= rows[j].r;
      wv(1'h1);
      chk("vec_num", vec_num, rows[j].n);
      chk("vec_addr", vec_addr, rows[j].c[1] ? rows[j].n * 4 : rows[j].n * 2);
      @(posedge pclk);
      rq <= 21'h0;
      wv(1'h0);
    end
    apb(1'h0, `IPVR_OFS_LEVEL, 32'h0);
    chk("level", q, 32'h0100);
    dly <= 4'hA;
    ci <= 1'h1;
    rq <= 21'h001000;
    repeat (4) @(negedge pclk);
    chk("masked", vec_valid, 32'h0);
    @(posedge pclk);
    ci <= 1'h0;
    wv(1'h1);
    @(posedge pclk);
    rq <= 21'h101000;
    repeat (3) @(negedge pclk);
    chk("held", vec_num, 32'h10);
    wv(1'h0);
    wv(1'h1);
    chk("next", vec_num, 32'h07);
    @(posedge pclk);
    rq <= 21'h0;
    repeat (2) @(negedge pclk);
    chk("withdrawn", vec_valid, 32'h0);
    apb(1'h1, `IPVR_OFS_INT_MASK, 32'h1);
    repeat (2) @(negedge pclk);
    chk("irq_out", irq_out, 32'h1);
    apb(1'h0, `IPVR_OFS_INT_STAT, 32'h0);
    chk("status", q, 32'h7);
    apb(1'h1, `IPVR_OFS_INT_MASK, 32'h0);
    repeat (2) @(negedge pclk);
    chk("irq_out masked", irq_out, 32'h0);
    apb(1'h1, `IPVR_OFS_INT_STAT, 32'h7);
    apb(1'h0, `IPVR_OFS_INT_STAT, 32'h0);
    chk("cleared", q, 32'h0);
    apb(1'h1, `IPVR_OFS_INT_MASK, 32'h1);
    rq <= 21'h001000;
    wv(1'h1);
    repeat (2) @(negedge pclk);
    chk("irq_out event", irq_out, 32'h1);
    @(posedge pclk);
    presetn <= 1'h0;
    rq <= 21'h0;
    @(negedge pclk);
    chk("reset vec_valid", vec_valid, 32'h0);
    chk("reset irq_out", irq_out, 32'h0);
    @(posedge pclk);
    presetn <= 1'h1;
    apb(1'h0, `IPVR_OFS_LEVEL, 32'h0);
    chk("reset level", q, 32'h0);
    apb(1'h0, `IPVR_OFS_VECTOR, 32'h0);
    chk("reset vector", q, 32'h0);
    apb(1'h0, `IPVR_OFS_INT_STAT, 32'h0);
    chk("reset status", q, 32'h0);
    end_of_test();
  end
endmodule // ipvr_resolver_tb_top
